// ### ldl_defs.svh
// constants of the loop dac serial loader
`ifndef LDL_DEFS_SVH
`define LDL_DEFS_SVH
`define LDL_SHIFT_W   17
`define LDL_NORM_W    16
`define LDL_CNT_W     5
`define LDL_NORM_MAX  5'h10
`define LDL_ALARM_MIN 5'h11
`define LDL_CNT_ZERO  5'h00
`define LDL_CNT_ONE   5'h01
`define LDL_OFS_4MA   17'h04000
`define LDL_CODE_RST  17'h00000
`define LDL_ACC_W     24
`define LDL_ACC_FS    24'h020000
`define LDL_ACC_RST   24'h000000
`define LDL_SYNC_RST  1'b0
`define LDL_RUN_DLY   4'h8
`endif

// ### ldl_pkg.sv
// types of the loop dac serial loader
package ldl_pkg;
  typedef enum logic {
    LDL_MODE_NORMAL = 1'b0,
    LDL_MODE_ALARM  = 1'b1
  } ldl_mode_t;

  typedef enum logic [1:0] {
    LDL_ST_IDLE = 2'b00,
    LDL_ST_CAPT = 2'b01,
    LDL_ST_OVLD = 2'b10,
    LDL_ST_WAKE = 2'b11
  } ldl_state_t;

  typedef struct packed {
    ldl_mode_t   mode;
    logic [16:0] code;
  } ldl_word_t;

  typedef struct packed {
    logic [4:0]  count;
    logic        frame;
    logic [16:0] shift;
  } ldl_link_t;
endpackage : ldl_pkg

// ### ldl_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
`include "ldl_defs.svh"
module ldl_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // level in and out
  input  wire logic d,
  output logic      q
);
  logic meta_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= `LDL_SYNC_RST;
      q      <= `LDL_SYNC_RST;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : ldl_sync

// ### ldl_sdm.sv
// second-order single-bit sigma-delta modulator
`timescale 1ns/1ps
`include "ldl_defs.svh"
module ldl_sdm (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // control and code
  input  wire logic        en,
  input  wire logic [16:0] code,
  // bit stream to the switched current source
  output logic             bit_q
);
  logic signed [`LDL_ACC_W-1:0] i1_q;
  logic signed [`LDL_ACC_W-1:0] i2_q;
  logic signed [`LDL_ACC_W-1:0] x;
  logic signed [`LDL_ACC_W-1:0] fb;
  logic signed [`LDL_ACC_W-1:0] i1_d;
  logic signed [`LDL_ACC_W-1:0] i2_d;

  // unipolar feedback of full scale; code is a fraction of 2^17
  always_comb begin
    x    = signed'({7'h00, code});
    fb   = bit_q ? signed'(`LDL_ACC_FS) : signed'(`LDL_ACC_RST);
    i1_d = i1_q + x - fb;
    i2_d = i2_q + i1_d - fb;
  end

  // disabled modulator holds cleared so it restarts from rest
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      i1_q  <= `LDL_ACC_RST;
      i2_q  <= `LDL_ACC_RST;
      bit_q <= 1'b0;
    end else if (!en) begin
      i1_q  <= `LDL_ACC_RST;
      i2_q  <= `LDL_ACC_RST;
      bit_q <= 1'b0;
    end else begin
      i1_q  <= i1_d;
      i2_q  <= i2_d;
      // strict compare: a zero code stays at rest, no runaway integrator
      bit_q <= (i2_d > signed'(`LDL_ACC_RST));
    end
  end
endmodule : ldl_sdm

// ### ldl_top.sv
// serial loader, dac latch and modulator control of the loop dac
`timescale 1ns/1ps
`include "ldl_defs.svh"
//
// Summary of operation
// - serial data shifts in on each serial clock rising edge, msb first
// - latch rising edge copies the shift register into the dac latch
// - serial clock edges between latch strobes are counted to pick mode
// - exactly sixteen edges give a normal word, sixteen-bit transfer
// - normal codes are straight binary, 4 mA to 20 mA, 244 nA steps
// - more than sixteen edges, counted modulo 32, give an alarm word of seventeen bits
// - on longer writes only the last seventeen bits are kept
// - alarm msb is clocked seventeen edges before latch, lsb last
// - alarm words go to the latch whole, 0 mA to 32 mA binary
// - count modulo 32: 0 to 16 normal, 17 to 31 alarm
// - reference overload resets: modulator off, oscillator off, latch 0
// - second-order modulator bit stream switches the current source
//
module ldl_top
  import ldl_pkg::*;
(
  // system clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // three-wire serial link
  input  wire logic        serial_clk,
  input  wire logic        serial_data,
  input  wire logic        latch,
  // reference output overload detector
  input  wire logic        reference_output_high,
  // dac latch and status
  output ldl_word_t        dac_q,
  output logic             word_loaded_q,
  output logic             osc_run_q,
  output logic             in_reset_q,
  // modulator bit stream
  output logic             mod_bit_q
);

  // ---------------- link clock domain ----------------
  logic [`LDL_SHIFT_W-1:0] shift_q;
  logic [`LDL_CNT_W-1:0]   count_q;
  logic                    frame_q;
  logic                    fresh_q;

  always_ff @(posedge serial_clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_q <= `LDL_CODE_RST;
    end else begin
      // 17-bit register keeps only the most recent bits
      shift_q <= {shift_q[`LDL_SHIFT_W-2:0], serial_data};
    end
  end

  // latch high marks the next edge as the first of a new write;
  // the clear waits for that edge so the count is still readable
  always_ff @(posedge serial_clk or posedge latch or negedge reset_n) begin
    if (!reset_n) begin
      fresh_q <= 1'b1;
    end else if (latch) begin
      fresh_q <= 1'b1;
    end else begin
      fresh_q <= 1'b0;
    end
  end

  // 5-bit counter wraps, which gives the modulo-32 count
  always_ff @(posedge serial_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= `LDL_CNT_ZERO;
    end else if (fresh_q) begin
      count_q <= `LDL_CNT_ONE;
    end else begin
      count_q <= count_q + `LDL_CNT_ONE;
    end
  end

  // flips once per write, so a strobe with no edges is seen as count 0
  always_ff @(posedge serial_clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_q <= 1'b0;
    end else if (fresh_q) begin
      frame_q <= !frame_q;
    end
  end

  // ---------------- system clock domain ----------------
  logic      latch_s;
  logic      ovld_s;
  logic      latch_d1_q;
  logic      latch_rise;
  ldl_link_t cap_q;
  logic      last_frame_q;
  logic [`LDL_CNT_W-1:0] eff_cnt;
  ldl_word_t next_word;
  ldl_state_t state_q;
  ldl_state_t state_d;
  logic [3:0] wake_q;

  ldl_sync u_latch_sync (
    .clk     (ref_clk),
    .reset_n (reset_n),
    .d       (latch),
    .q       (latch_s)
  );

  ldl_sync u_ovld_sync (
    .clk     (ref_clk),
    .reset_n (reset_n),
    .d       (reference_output_high),
    .q       (ovld_s)
  );

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      latch_d1_q <= 1'b0;
    end else begin
      latch_d1_q <= latch_s;
    end
  end

  assign latch_rise = latch_s && !latch_d1_q;

  // link words are read only once latch is high; the host has stopped
  // the serial clock by then, so they stand still across the crossing
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cap_q <= '0;
    end else if (latch_rise) begin
      cap_q.count <= count_q;
      cap_q.frame <= frame_q;
      cap_q.shift <= shift_q;
    end
  end

  // frame of the previous strobe, taken at every strobe, dropped ones too,
  // so a write after a refused strobe still counts its own edges
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      last_frame_q <= 1'b0;
    end else if (latch_rise) begin
      last_frame_q <= cap_q.frame;
    end
  end

  // unchanged frame means no edges since the previous strobe
  always_comb begin
    if (cap_q.frame == last_frame_q) begin
      eff_cnt = `LDL_CNT_ZERO;
    end else begin
      eff_cnt = cap_q.count;
    end
  end

  always_comb begin
    if (eff_cnt >= `LDL_ALARM_MIN) begin
      next_word.mode = LDL_MODE_ALARM;
      next_word.code = cap_q.shift;
    end else begin
      next_word.mode = LDL_MODE_NORMAL;
      // normal lsb and alarm lsb are both 244 nA, so only offset
      next_word.code = `LDL_OFS_4MA
                     + {1'b0, cap_q.shift[`LDL_NORM_W-1:0]};
    end
  end

  always_comb begin
    state_d = state_q;
    if (ovld_s) begin
      state_d = LDL_ST_OVLD;
    end else begin
      case (state_q)
        LDL_ST_IDLE: begin
          if (latch_rise) begin
            state_d = LDL_ST_CAPT;
          end
        end
        LDL_ST_CAPT: begin
          state_d = LDL_ST_IDLE;
        end
        LDL_ST_OVLD: begin
          state_d = LDL_ST_WAKE;
        end
        LDL_ST_WAKE: begin
          if (wake_q == 4'h0) begin
            state_d = LDL_ST_IDLE;
          end
        end
        default: begin
          state_d = LDL_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= LDL_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // short restart delay models the oscillator coming back up
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_q <= 4'h0;
    end else if (state_q == LDL_ST_OVLD) begin
      wake_q <= `LDL_RUN_DLY;
    end else if (wake_q != 4'h0) begin
      wake_q <= wake_q - 4'h1;
    end
  end

  // strobes arriving during overload or wake-up are dropped
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dac_q <= '0;
    end else if (ovld_s) begin
      dac_q <= '0;
    end else if (state_q == LDL_ST_CAPT) begin
      dac_q <= next_word;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      word_loaded_q <= 1'b0;
    end else begin
      word_loaded_q <= (state_q == LDL_ST_CAPT) && !ovld_s;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_run_q  <= 1'b1;
      in_reset_q <= 1'b0;
    end else begin
      osc_run_q  <= !ovld_s && (state_q != LDL_ST_OVLD);
      in_reset_q <= ovld_s || (state_q == LDL_ST_OVLD)
                    || (state_q == LDL_ST_WAKE);
    end
  end

  ldl_sdm u_sdm (
    .clk     (ref_clk),
    .reset_n (reset_n),
    .en      (osc_run_q),
    .code    (dac_q.code),
    .bit_q   (mod_bit_q)
  );

  // ---------------- checks ----------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_load_follows_latch: assert property (
    latch_rise && state_q == LDL_ST_IDLE && !ovld_s ##1 !ovld_s
    |-> ##1 word_loaded_q
  ) else $error("latch edge did not load the dac latch");

  a_norm_offset_map: assert property (
    word_loaded_q && dac_q.mode == LDL_MODE_NORMAL
    |-> dac_q.code == `LDL_OFS_4MA
                      + {1'b0, $past(cap_q.shift[`LDL_NORM_W-1:0])}
  ) else $error("normal code not offset by 4 mA");

  a_mode_by_count: assert property (
    word_loaded_q
    |-> (dac_q.mode == LDL_MODE_ALARM) == ($past(eff_cnt) >= 5'h11)
  ) else $error("mode does not follow the edge count");

  a_sixteen_normal: assert property (
    state_q == LDL_ST_CAPT && eff_cnt == 5'h10 && !ovld_s
    |=> dac_q.mode == LDL_MODE_NORMAL
        && dac_q.code == `LDL_OFS_4MA + {1'b0, $past(cap_q.shift[15:0])}
  ) else $error("sixteen edges did not give a normal word");

  a_alarm_whole: assert property (
    word_loaded_q && dac_q.mode == LDL_MODE_ALARM
    |-> dac_q.code == $past(cap_q.shift)
  ) else $error("alarm word not transferred whole");

  a_overload_clears: assert property (
    ovld_s |=> dac_q.code == 17'h00000 && !osc_run_q ##1 !mod_bit_q
  ) else $error("overload did not clear latch and stop modulator");

  a_mod_runs: assert property (
    osc_run_q && dac_q.code >= 17'h04000
    |-> ##[1:40] (mod_bit_q || !osc_run_q)
  ) else $error("modulator gave no ones at or above 4 mA");

  a_count_restart: assert property (
    @(posedge serial_clk) disable iff (!reset_n)
    fresh_q |=> count_q == 5'h01
  ) else $error("edge count did not restart after latch");

  a_shift_msb_first: assert property (
    @(posedge serial_clk) disable iff (!reset_n)
    ##2 1'b1 |-> shift_q[1] == $past(serial_data, 2)
  ) else $error("serial data not shifted toward the msb");

  c_normal_load: cover property (
    word_loaded_q && dac_q.mode == LDL_MODE_NORMAL
  );

  c_alarm_load: cover property (
    word_loaded_q && dac_q.mode == LDL_MODE_ALARM
  );

  c_overload: cover property (
    $fell(ovld_s) ##[1:40] state_q == LDL_ST_IDLE
  );

  c_empty_write: cover property (
    state_q == LDL_ST_CAPT && eff_cnt == 5'h00
  );

  c_refused_strobe: cover property (
    latch_rise && in_reset_q
  );

  a_load_once: assert property (
    word_loaded_q |=> !word_loaded_q
  ) else $error("load pulse lasted more than one cycle");

  a_osc_stopped: assert property (
    state_q == LDL_ST_OVLD |=> !osc_run_q
  ) else $error("oscillator kept running in overload");

  a_reset_no_load: assert property (
    in_reset_q |-> !word_loaded_q
  ) else $error("word loaded while in reset state");

  a_wake_holds: assert property (
    $fell(ovld_s) |=> in_reset_q [*8]
  ) else $error("reset state left before wake-up delay");

  a_empty_normal: assert property (
    state_q == LDL_ST_CAPT && cap_q.frame == last_frame_q && !ovld_s
    |=> dac_q.mode == LDL_MODE_NORMAL
  ) else $error("strobe with no edges did not give a normal word");

endmodule : ldl_top

// ### ldl_host_model.sv
// host serial port model driving the three-wire link
`timescale 1ns/1ps
module ldl_host_model (
  // three-wire link
  output logic serial_clk,
  output logic serial_data,
  output logic latch
);
  initial begin
    serial_clk  = 1'b0;
    serial_data = 1'b0;
    latch       = 1'b0;
  end

  // clock rests low between frames; odd offset keeps phase unrelated
  task automatic send(input int n, input logic [63:0] bits);
    #3.3;
    latch = 1'b0;
    #160;
    for (int i = n - 1; i >= 0; i--) begin
      serial_data = bits[i];
      #80 serial_clk = 1'b1;
      #80 serial_clk = 1'b0;
    end
    // released line must not keep showing the last bit
    serial_data = ~serial_data;
    #80 latch = 1'b1;
  endtask : send
endmodule : ldl_host_model

// ### test_loop_dac_serial_loader.sv
// self-checking bench of the loop dac serial loader
`timescale 1ns/1ps
module test_loop_dac_serial_loader;
  import ldl_pkg::*;
  localparam logic [63:0] PAT = 64'h5A5A_F0F0_3C3C_A5A5;
  localparam int LIMIT = 40000;
  logic      ref_clk = 1'b0;
  logic      reset_n = 1'b0;
  logic      ovld    = 1'b0;
  logic      serial_clk, serial_data, latch;
  ldl_word_t dac_q;
  logic      word_loaded_q, osc_run_q, in_reset_q, mod_bit_q;
  int        error_cnt = 0;
  int        n_tests   = 0;
  int        cycles    = 0;

  always #5 ref_clk = ~ref_clk;

  ldl_top i_ldl_top (
    .ref_clk(ref_clk), .reset_n(reset_n),
    .serial_clk(serial_clk), .serial_data(serial_data), .latch(latch),
    .reference_output_high(ovld), .dac_q(dac_q),
    .word_loaded_q(word_loaded_q), .osc_run_q(osc_run_q),
    .in_reset_q(in_reset_q), .mod_bit_q(mod_bit_q)
  );

  ldl_host_model i_ldl_host_model (
    .serial_clk(serial_clk), .serial_data(serial_data), .latch(latch)
  );

  task automatic check_word(input string what, input ldl_word_t exp,
                            input ldl_word_t got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  task automatic check_bit(input string what, input logic exp,
                           input logic got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  function automatic ldl_word_t exp_word(input int n, input logic [63:0] b);
    if (n % 32 > 16) return '{LDL_MODE_ALARM, b[16:0]};
    return '{LDL_MODE_NORMAL, {1'b0, b[15:0]} + 17'h04000};
  endfunction : exp_word

  // bounded wait covers sync, capture and load of one commit
  task automatic write(input int n, input logic [63:0] b,
                       input logic ok);
    logic seen;
    seen = 1'b0;
    i_ldl_host_model.send(n, b);
    repeat (20) begin
      @(negedge ref_clk);
      if (word_loaded_q === 1'b1) seen = 1'b1;
    end
    check_bit("word_loaded_q", ok, seen);
    if (ok) check_word("dac_q", exp_word(n, b), dac_q);
  endtask : write

  task automatic t_reset;
    check_word("dac_q", '{LDL_MODE_NORMAL, 17'h00000}, dac_q);
    check_bit("osc_run_q", 1'b1, osc_run_q);
    check_bit("in_reset_q", 1'b0, in_reset_q);
    check_bit("mod_bit_q", 1'b0, mod_bit_q);
    $display("test reset done");
  endtask : t_reset

  task automatic t_normal;
    logic [63:0] v [3] = '{64'hABCD, 64'hFFFF, 64'h0000};
    foreach (v[i]) write(16, v[i], 1'b1);
    $display("test normal done");
  endtask : t_normal

  task automatic t_alarm;
    write(17, 64'h03C00, 1'b1);
    write(24, {40'h0, 7'h7F, 17'h18000}, 1'b1);
    $display("test alarm done");
  endtask : t_alarm

  // 8 then 16 exposes a counter that does not restart; 0 is an empty strobe
  task automatic t_modulo;
    int cnt [8] = '{17, 31, 32, 33, 8, 16, 16, 0};
    foreach (cnt[i]) write(cnt[i], PAT, 1'b1);
    $display("test modulo done");
  endtask : t_modulo

  task automatic t_overload;
    write(17, 64'h10000, 1'b1);
    @(posedge ref_clk) #1 ovld = 1'b1;
    repeat (6) @(negedge ref_clk);
    check_word("dac_q", '{LDL_MODE_NORMAL, 17'h00000}, dac_q);
    check_bit("osc_run_q", 1'b0, osc_run_q);
    check_bit("in_reset_q", 1'b1, in_reset_q);
    check_bit("mod_bit_q", 1'b0, mod_bit_q);
    write(16, 64'h1234, 1'b0);
    @(posedge ref_clk) #1 ovld = 1'b0;
    repeat (20) @(negedge ref_clk);
    check_bit("in_reset_q", 1'b0, in_reset_q);
    check_bit("osc_run_q", 1'b1, osc_run_q);
    // alarm word after a refused strobe: the count must be its own
    write(17, 64'h0C001, 1'b1);
    $display("test overload done");
  endtask : t_overload

  // ones density of the bit stream tracks code over full scale
  task automatic t_modulator;
    logic [63:0] c [2] = '{64'h10000, 64'h08000};
    int          want [2] = '{512, 256};
    int          ones;
    foreach (c[i]) begin
      write(17, c[i], 1'b1);
      repeat (64) @(negedge ref_clk);
      ones = 0;
      repeat (1024) begin
        @(negedge ref_clk);
        if (mod_bit_q === 1'b1) ones++;
      end
      check_bit("mod density", 1'b1,
                ones > want[i] - 12 && ones < want[i] + 12);
    end
    $display("test modulator done");
  endtask : t_modulator

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      error_cnt++;
      $display("[FAIL] run time expected below %0d seen %0d", LIMIT, cycles);
      test_done;
    end
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    t_reset;
    t_normal;
    t_alarm;
    t_modulo;
    t_overload;
    t_modulator;
    test_done;
  end
endmodule : test_loop_dac_serial_loader
